/* File: dv/pti_host_model.sv */
// Host controller model: master on the two-wire register bus.
// Assumes an open-drain data wire with pull-up, resolved by the bench.
module pti_host_model
  import pti_pkg::*;
(
  output logic       scl,      // Serial clock, driven by host only
  output logic       sda_rel,  // 1 = let data line float high
  input  wire logic  sda,      // Resolved data line level
  output logic       rd_valid, // Short pulse when a read byte lands
  output logic [7:0] rd_data   // Last byte read
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam realtime QTR = 31.25ns; // Quarter of the 125 ns bit period

  // Idle bus: clock high, data released
  initial begin
    scl      = 1'b1;
    sda_rel  = 1'b1;
    rd_valid = 1'b0;
    rd_data  = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // One bit: data set with clock low, held until after the sample point
  task automatic bit_io(input logic b, output logic s);
    sda_rel = b;
    #QTR scl = 1'b1;
    #QTR s = sda;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  // Start or repeated start: data falls while clock high
  task automatic start_c();
    sda_rel = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_rel = 1'b0;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  // Stop: data rises while clock high
  task automatic stop_c();
    sda_rel = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_rel = 1'b1;
    #QTR;
  endtask

  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] w, input logic ack_out,
                      output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], s);
      r[i] = s;
    end
    bit_io(ack_out, ack);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Register write: target address, pointer, data; ok when all acked
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a,
                           input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       k0;
    logic       k1;
    logic       k2;
    #1;  // Keep pin changes off the clk edges
    start_c();
    xfer({dev, 1'b0}, 1'b1, r, k0);
    xfer(a, 1'b1, r, k1);
    xfer(d, 1'b1, r, k2);
    stop_c();
    ok = !(k0 | k1 | k2);
  endtask

  // Register read: pointer write, repeated start, one byte, no-ack, stop
  task automatic read_reg(input logic [7:0] a);
    logic [7:0] r;
    logic       k;
    #1;  // Keep pin changes off the clk edges
    start_c();
    xfer({DEV_ADDR_DEF, 1'b0}, 1'b1, r, k);
    xfer(a, 1'b1, r, k);
    start_c();
    xfer({DEV_ADDR_DEF, 1'b1}, 1'b1, r, k);
    xfer(8'hff, 1'b1, r, k);
    stop_c();
    rd_data  = r;
    rd_valid = 1'b1;
    #1 rd_valid = 1'b0;
  endtask
endmodule

/* File: dv/pti_top_tb.sv */
// Self-checking bench for the proximity threshold block.
// Assumes the host model above and the 03h start / W1C status scheme.
module pti_top_tb
  import pti_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;      // 100 MHz system clock
  logic        reset_n = 1'b0;  // Async reset, active low
  logic        ce = 1'b1;       // Always running
  logic        meas_done = 1'b0, als_done = 1'b0;
  logic [15:0] meas_data = 16'h0000, als_data = 16'h0000;
  logic        scl, sda_rel, sda, sda_out, sda_oe_n, int_n, meas_start;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic [7:0]  exp_q[$];        // Expected read bytes, oldest first
  logic [15:0] rng = 16'h005c;  // Random state
  logic [15:0] thr;             // Chosen threshold
  logic        ok;
  int          fails = 0, checks = 0, starts = 0, s0;
  // Offsets read back at their defaults, unmapped one last
  logic [7:0]  dflt[9] = '{8'h80, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h87, 8'h90};

  always #5 clk = ~clk;
  assign sda = sda_rel & (sda_oe_n | sda_out);  // Pull-up wire, device drives its value when enabled

  pti_top #(.MEAS_PERIOD(50)) pti_top_inst (
    .clk(clk), .reset_n(reset_n), .ce(ce), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_n(int_n),
    .meas_start(meas_start), .meas_done(meas_done), .meas_data(meas_data),
    .als_done(als_done), .als_data(als_data));

  pti_host_model pti_host_model_inst (
    .scl(scl), .sda_rel(sda_rel), .sda(sda), .rd_valid(rd_valid), .rd_data(rd_data));

  ////////////////////////////////////////////////////////////////////////
  // Compare helpers
  task automatic chk_bit(input logic e, input logic a, input string what);
    checks++;
    if (a !== e) begin
      fails++;
      $display("[ERR] %0t %s: got %b want %b", $time, what, a, e);
    end
  endtask

  task automatic chk_byte(input logic [7:0] e, input logic [7:0] a);
    checks++;
    if (a !== e) begin
      fails++;
      $display("[ERR] %0t read: got %h want %h", $time, a, e);
    end
  endtask

  // Read watcher: each landed byte against the oldest note
  always @(posedge rd_valid) begin
    if (exp_q.size() == 0) begin
      fails++;
      $display("[ERR] %0t read with no expectation", $time);
    end else begin
      chk_byte(exp_q.pop_front(), rd_data);
    end
  end

  // Measurement request counter
  always @(posedge clk) begin
    if (meas_start === 1'b1) starts++;
  end

  function automatic logic [15:0] xs(input logic [15:0] s);
    logic [15:0] x;
    x = s ^ (s << 7);
    x = x ^ (x >> 9);
    return x ^ (x << 8);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus and result tasks
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(negedge clk);
    pti_host_model_inst.read_reg(a);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    pti_host_model_inst.write_reg(DEV_ADDR_DEF, a, d, ok);
    chk_bit(1'b1, ok, "write ack");
  endtask

  // One result on the proximity or ambient path, then settle
  task automatic res(input logic [15:0] v, input logic als);
    @(negedge clk);
    if (als) begin
      als_done = 1'b1;
      als_data = v;
    end else begin
      meas_done = 1'b1;
      meas_data = v;
    end
    @(negedge clk);
    meas_done = 1'b0;
    als_done  = 1'b0;
    meas_data = xs(v);
    repeat (3) @(negedge clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard, well past the expected run
  initial begin
    #700us;
    fails++;
    $display("[ERR] %0t run did not finish", $time);
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    // Defaults, unmapped offset included
    foreach (dflt[i])
      rd(dflt[i], 8'h00);
    chk_bit(1'b1, starts == 0, "idle requests");
    $display("test defaults done");
    // Wrong target address is not acked and writes nothing
    @(negedge clk);
    pti_host_model_inst.write_reg(DEV_ADDR_DEF ^ 7'h01, 8'h8c, 8'h5a, ok);
    chk_bit(1'b0, ok, "foreign address ack");
    rd(8'h8c, 8'h00);
    wr(8'h90, 8'h77);
    rd(8'h90, 8'h00);
    $display("test refusals done");
    // Random upper threshold, byte halves
    rng = xs(rng);
    thr = {1'b0, rng[14:0]} | 16'h0100;
    wr(8'h8c, thr[15:8]);
    wr(8'h8d, thr[7:0]);
    rd(8'h8c, thr[15:8]);
    rd(8'h8d, thr[7:0]);
    wr(8'h89, 8'h22);
    rd(8'h89, 8'h22);
    wr(8'h80, 8'h03);
    rd(8'h80, 8'h03);
    #400us;
    @(negedge clk);
    s0 = starts;
    repeat (500) @(negedge clk);
    chk_bit(1'b1, starts - s0 == 10, "periodic requests");
    $display("test start done");
    // Upper crossing needs two consecutive results at or above
    res(thr, 1'b0);
    res(thr - 16'h0001, 1'b0);
    chk_bit(1'b1, int_n, "single high");
    res(thr, 1'b0);
    chk_bit(1'b1, int_n, "first of run");
    res(thr, 1'b0);
    chk_bit(1'b0, int_n, "second of run");
    rd(8'h8e, 8'h01);
    rd(8'h87, thr[15:8]);
    rd(8'h88, thr[7:0]);
    wr(8'h8e, 8'h01);
    chk_bit(1'b1, int_n, "cleared");
    rd(8'h8e, 8'h00);
    $display("test upper done");
    // Lower crossing is strict below
    wr(8'h8c, 8'hff);
    wr(8'h8d, 8'hff);
    wr(8'h8a, thr[15:8]);
    wr(8'h8b, thr[7:0]);
    res(thr, 1'b0);
    res(thr - 16'h0001, 1'b0);
    chk_bit(1'b1, int_n, "first low");
    res(thr - 16'h0001, 1'b0);
    chk_bit(1'b0, int_n, "second low");
    rd(8'h8e, 8'h02);
    wr(8'h8e, 8'h02);
    $display("test lower done");
    // Enable off, then ambient source select
    wr(8'h8a, 8'h00);
    wr(8'h8b, 8'h00);
    wr(8'h8c, thr[15:8]);
    wr(8'h8d, thr[7:0]);
    wr(8'h89, 8'h20);
    res(thr, 1'b0);
    res(thr, 1'b0);
    chk_bit(1'b1, int_n, "enable off");
    wr(8'h89, 8'h23);
    res(thr, 1'b0);
    res(thr, 1'b0);
    chk_bit(1'b1, int_n, "prox ignored");
    res(thr, 1'b1);
    res(thr, 1'b1);
    chk_bit(1'b0, int_n, "ambient run");
    rd(8'h8e, 8'h01);
    $display("test select done");
    wrap_up();
  end
endmodule

/* File: rtl/pti_i2c_slave.sv */
// Serial two-wire target: address match, pointer byte, writes, reads.
// Assumes scl/sda come from pins; sampled on clk, bus much slower than clk.
module pti_i2c_slave
  import pti_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = pti_pkg::DEV_ADDR_DEF
) (
  input  wire logic   clk,
  input  wire logic   reset_n,
  input  wire logic   ce,
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  output logic        sda_oe_n,
  pti_reg_if.master   rif
);
  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers and previous-sample copies
  logic scl_m_q, scl_s_q, scl_p_q;  // Clock line stages
  logic sda_m_q, sda_s_q, sda_p_q;  // Data line stages
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else if (ce) begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_in, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_in, sda_m_q, sda_s_q};
    end
  end
  // Bus events
  logic rise, fall, start, stop;
  assign rise  = scl_s_q & ~scl_p_q;
  assign fall  = ~scl_s_q & scl_p_q;
  assign start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  ////////////////////////////////////////////////////////////////////
  // Byte engine
  pti_state_t st_q, st_d;       // Engine state
  logic [2:0] bit_q, bit_d;     // Bit counter
  logic [7:0] sh_q, sh_d;       // Shift register
  logic [7:0] ptr_q, ptr_d;     // Register pointer
  logic       drv_q, drv_d;     // Pulling data line low
  logic       rw_q, rw_d;       // Read transfer
  logic       ph_q, ph_d;       // Next write byte is the pointer
  logic       more_q, more_d;   // Data byte written / master acked
  logic       wr_q, wr_d;       // Write strobe
  always_comb begin
    st_d = st_q; bit_d = bit_q; sh_d = sh_q; ptr_d = ptr_q;
    drv_d = drv_q; rw_d = rw_q; ph_d = ph_q; more_d = more_q; wr_d = 1'b0;
    if (stop) begin
      st_d = S_IDLE;
      drv_d = 1'b0;
    end else if (start) begin
      st_d = S_ADDR;
      bit_d = 3'h0;
      drv_d = 1'b0;
    end else begin
      unique case (st_q)
        S_IDLE: ;
        S_ADDR: if (rise) begin
          sh_d = {sh_q[6:0], sda_s_q};
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            // Address byte done: ack only our own address
            st_d = (sh_q[6:0] == DEV_ADDR) ? S_AACK : S_IDLE;
            rw_d = sda_s_q;
          end
        end
        S_AACK, S_WACK: if (fall) begin
          if (!drv_q) begin
            drv_d = 1'b1;                // Drive ack bit
          end else begin
            drv_d = 1'b0;
            bit_d = 3'h0;
            if (st_q == S_AACK && rw_q) begin
              sh_d = rif.rdata;          // Load first read byte
              drv_d = ~rif.rdata[7];
              ptr_d = ptr_q + 8'h01;
              st_d = S_RBYTE;
            end else begin
              if (st_q == S_AACK) begin
                ph_d = 1'b1;
              end
              if (st_q == S_WACK && more_q) begin
                ptr_d = ptr_q + 8'h01;   // Auto-increment after data
              end
              st_d = S_WBYTE;
            end
          end
        end
        S_WBYTE: if (rise) begin
          sh_d = {sh_q[6:0], sda_s_q};
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            st_d = S_WACK;
            more_d = ~ph_q;
            ph_d = 1'b0;
            if (ph_q) begin
              ptr_d = {sh_q[6:0], sda_s_q};
            end else begin
              wr_d = 1'b1;
            end
          end
        end
        S_RBYTE: if (fall) begin
          if (bit_q == 3'h7) begin
            drv_d = 1'b0;                // Release for master ack
            st_d = S_RACK;
          end else begin
            bit_d = bit_q + 3'h1;
            sh_d = {sh_q[6:0], 1'b0};
            drv_d = ~sh_q[6];
          end
        end
        S_RACK: begin
          if (rise) begin
            more_d = ~sda_s_q;
          end else if (fall) begin
            bit_d = 3'h0;
            if (more_q) begin
              sh_d = rif.rdata;          // Next sequential byte
              drv_d = ~rif.rdata[7];
              ptr_d = ptr_q + 8'h01;
              st_d = S_RBYTE;
            end else begin
              st_d = S_IDLE;
            end
          end
        end
      endcase
    end
  end
  // Engine registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= S_IDLE; bit_q <= 3'h0; sh_q <= 8'h00; ptr_q <= 8'h00;
      drv_q <= 1'b0; rw_q <= 1'b0; ph_q <= 1'b0; more_q <= 1'b0; wr_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d; bit_q <= bit_d; sh_q <= sh_d; ptr_q <= ptr_d;
      drv_q <= drv_d; rw_q <= rw_d; ph_q <= ph_d; more_q <= more_d; wr_q <= wr_d;
    end
  end
  // Outputs toward pin and register file
  assign sda_oe_n  = ~drv_q;
  assign rif.wr    = wr_q & ce;
  assign rif.addr  = ptr_q;
  assign rif.wdata = sh_q;
endmodule

/* File: rtl/pti_pkg.sv */
// Constants and types shared by the proximity threshold block.
// Assumes a single 100 MHz clock domain.
package pti_pkg;
  // Serial bus target address (write byte 26h on the wire)
  localparam logic [6:0] DEV_ADDR_DEF   = 7'h13;
  // Register offsets
  localparam logic [7:0] REG_CMD        = 8'h80;
  localparam logic [7:0] REG_RES_HI     = 8'h87;
  localparam logic [7:0] REG_RES_LO     = 8'h88;
  localparam logic [7:0] REG_INTCTL     = 8'h89;
  localparam logic [7:0] REG_LO_TH_HB   = 8'h8a;
  localparam logic [7:0] REG_LO_TH_LB   = 8'h8b;
  localparam logic [7:0] REG_HI_TH_HB   = 8'h8c;
  localparam logic [7:0] REG_HI_TH_LB   = 8'h8d;
  localparam logic [7:0] REG_STATUS     = 8'h8e;
  // Command register fields
  localparam int         CMD_SELFTIMED  = 0;
  localparam int         CMD_PROX_EN    = 1;
  // Interrupt control fields
  localparam int         IC_SEL         = 0;
  localparam int         IC_EN          = 1;
  localparam int         IC_CNT_LSB     = 5;
  // Status fields
  localparam int         ST_HI          = 0;
  localparam int         ST_LO          = 1;
  // Reset values
  localparam logic [1:0]  CMD_RST       = 2'h0;
  localparam logic [7:0]  INTCTL_RST    = 8'h00;
  localparam logic [15:0] TH_RST        = 16'h0000;
  // Measurement rate in milli-hertz and the derived period
  localparam longint     CLK_HZ         = 100_000_000;
  localparam longint     MEAS_RATE_MHZ  = 3900;
  localparam int         MEAS_PERIOD_CYC = int'((CLK_HZ * 1000) / MEAS_RATE_MHZ);
  // Serial engine states
  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_ADDR  = 7'h02,
    S_AACK  = 7'h04,
    S_WBYTE = 7'h08,
    S_WACK  = 7'h10,
    S_RBYTE = 7'h20,
    S_RACK  = 7'h40
  } pti_state_t;
endpackage

/* File: rtl/pti_reg_if.sv */
// Register access path between the serial engine and the register file.
// Assumes both ends run on the same clock.
interface pti_reg_if;
  logic       wr;     // One-cycle write strobe
  logic [7:0] addr;   // Register pointer
  logic [7:0] wdata;  // Write data
  logic [7:0] rdata;  // Read data for addr
  modport master (output wr, output addr, output wdata, input rdata);
  modport target (input wr, input addr, input wdata, output rdata);
endinterface

/* File: rtl/pti_top.sv */
// Proximity threshold and interrupt block with its register file.
// Assumes a front end that returns results on meas_done/als_done (clk domain).
// How it works
// RULE1: Writing 03h at 80h starts timed proximity
// RULE2: Status bit 0 shows upper-threshold event
// RULE3: Enough consecutive high results pull interrupt low
// RULE4: Host reads status register 8Eh after interrupt
// RULE5: Compare each count with 16-bit upper threshold
// RULE6: All registers come up with defaults
// RULE7: Thresholds split high byte, low byte
// RULE8: 89h holds count, enable, source select
// RULE9: Low results for count set low flag
// RULE10: Host waits 400 us after start
module pti_top
  import pti_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR    = pti_pkg::DEV_ADDR_DEF,
  parameter int         MEAS_PERIOD = pti_pkg::MEAS_PERIOD_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  output logic             int_n,
  output logic             meas_start,
  input  wire logic        meas_done,
  input  wire logic [15:0] meas_data,
  input  wire logic        als_done,
  input  wire logic [15:0] als_data
);
  import pti_pkg::*;
  ////////////////////////////////////////////////////////////////////
  // Serial engine
  pti_reg_if rif ();
  pti_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_slave (
    .clk      (clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_oe_n (sda_oe_n),
    .rif      (rif.master)
  );
  assign sda_out = 1'b0;  // Open drain: only ever pulls low
  ////////////////////////////////////////////////////////////////////
  // Helpers
  // Saturating increment of a run counter
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction
  // Write strobe decode for one offset
  function automatic logic hit(input logic [7:0] off);
    return rif.wr && (rif.addr == off);
  endfunction
  ////////////////////////////////////////////////////////////////////
  // State
  logic [1:0]  cmd_q, cmd_d;        // Self-timed and proximity enables
  logic [7:0]  ic_q, ic_d;          // Interrupt control
  logic [15:0] lo_th_q, lo_th_d;    // Lower threshold
  logic [15:0] hi_th_q, hi_th_d;    // Upper threshold
  logic [15:0] res_q, res_d;        // Last proximity result
  logic        upper_crossing_flag_q, upper_crossing_flag_d;
  logic        lower_crossing_flag_q, lower_crossing_flag_d;
  logic [7:0]  hi_cnt_q, hi_cnt_d;  // Consecutive high results
  logic [7:0]  lo_cnt_q, lo_cnt_d;  // Consecutive low results
  logic [31:0] tmr_q, tmr_d;        // Measurement period timer
  logic        start_q, start_d;    // Measurement request
  logic        int_n_q, int_n_d;    // Interrupt pin level
  // Decoded controls
  logic        run;                 // Self-timed proximity running
  logic [7:0]  need;                // Required consecutive count
  logic        smp_done;            // Selected result strobe
  logic [15:0] smp;                 // Selected result
  logic        hi_hit, lo_hit;      // Result at or above upper, below lower threshold
  logic        hi_set, lo_set;      // Flag set events
  assign run      = cmd_q[CMD_SELFTIMED] & cmd_q[CMD_PROX_EN];
  assign need     = 8'h01 << ic_q[IC_CNT_LSB +: 3];
  assign smp_done = ic_q[IC_SEL] ? als_done : meas_done;
  assign smp      = ic_q[IC_SEL] ? als_data : meas_data;
  assign hi_hit   = smp >= hi_th_q;
  assign lo_hit   = smp < lo_th_q;
  ////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    cmd_d = cmd_q; ic_d = ic_q; lo_th_d = lo_th_q; hi_th_d = hi_th_q;
    res_d = res_q; hi_cnt_d = hi_cnt_q; lo_cnt_d = lo_cnt_q;
    hi_set = 1'b0; lo_set = 1'b0; start_d = 1'b0;
    // Register writes
    if (hit(REG_CMD)) begin
      cmd_d = rif.wdata[1:0];                     // RULE1
    end
    if (hit(REG_INTCTL)) begin
      ic_d = rif.wdata;                           // RULE8
    end
    if (hit(REG_LO_TH_HB)) begin
      lo_th_d[15:8] = rif.wdata;                  // RULE7
    end
    if (hit(REG_LO_TH_LB)) begin
      lo_th_d[7:0] = rif.wdata;                   // RULE7
    end
    if (hit(REG_HI_TH_HB)) begin
      hi_th_d[15:8] = rif.wdata;                  // RULE7
    end
    if (hit(REG_HI_TH_LB)) begin
      hi_th_d[7:0] = rif.wdata;                   // RULE7
    end
    // Periodic measurement timer, first request right after start
    if (!run) begin
      tmr_d = 32'h0;
    end else if (tmr_q == 32'h0) begin
      start_d = 1'b1;                             // RULE1
      tmr_d = 32'(MEAS_PERIOD - 1);
    end else begin
      tmr_d = tmr_q - 32'h1;
    end
    // Result capture and run counting
    if (meas_done) begin
      res_d = meas_data;
    end
    if (smp_done) begin
      hi_cnt_d = hi_hit ? sat_inc(hi_cnt_q) : 8'h00;   // RULE5
      lo_cnt_d = lo_hit ? sat_inc(lo_cnt_q) : 8'h00;   // RULE9
      hi_set = ic_q[IC_EN] && hi_hit && hi_cnt_d == need;   // RULE3
      lo_set = ic_q[IC_EN] && lo_hit && lo_cnt_d == need;   // RULE9
    end
    // New control setting starts both runs afresh, else a run left over
    // from the old source or count would skip past the exact Nth result
    if (hit(REG_INTCTL)) begin
      hi_cnt_d = 8'h00;                           // RULE8
      lo_cnt_d = 8'h00;                           // RULE8
    end
    // Sticky flags, write one to clear, set wins
    upper_crossing_flag_d = hi_set |
      (upper_crossing_flag_q & ~(hit(REG_STATUS) & rif.wdata[ST_HI]));   // RULE2
    lower_crossing_flag_d = lo_set |
      (lower_crossing_flag_q & ~(hit(REG_STATUS) & rif.wdata[ST_LO]));   // RULE9
    // Pin low while any flag stands
    int_n_d = ~(upper_crossing_flag_d | lower_crossing_flag_d);   // RULE3
  end
  // State registers, defaults after reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_q <= CMD_RST; ic_q <= INTCTL_RST;       // RULE6
      lo_th_q <= TH_RST; hi_th_q <= TH_RST;       // RULE6
      res_q <= 16'h0000; hi_cnt_q <= 8'h00; lo_cnt_q <= 8'h00;
      upper_crossing_flag_q <= 1'b0; lower_crossing_flag_q <= 1'b0;
      tmr_q <= 32'h0; start_q <= 1'b0; int_n_q <= 1'b1;
    end else if (ce) begin
      cmd_q <= cmd_d; ic_q <= ic_d; lo_th_q <= lo_th_d; hi_th_q <= hi_th_d;
      res_q <= res_d; hi_cnt_q <= hi_cnt_d; lo_cnt_q <= lo_cnt_d;
      upper_crossing_flag_q <= upper_crossing_flag_d;
      lower_crossing_flag_q <= lower_crossing_flag_d;
      tmr_q <= tmr_d; start_q <= start_d; int_n_q <= int_n_d;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Read mux, unmapped offsets read zero
  always_comb begin
    unique case (rif.addr)
      REG_CMD:      rif.rdata = {6'h00, cmd_q};
      REG_RES_HI:   rif.rdata = res_q[15:8];
      REG_RES_LO:   rif.rdata = res_q[7:0];
      REG_INTCTL:   rif.rdata = ic_q;
      REG_LO_TH_HB: rif.rdata = lo_th_q[15:8];
      REG_LO_TH_LB: rif.rdata = lo_th_q[7:0];
      REG_HI_TH_HB: rif.rdata = hi_th_q[15:8];
      REG_HI_TH_LB: rif.rdata = hi_th_q[7:0];
      REG_STATUS:   rif.rdata = {6'h00, lower_crossing_flag_q,
                                 upper_crossing_flag_q};   // RULE4
      default:      rif.rdata = 8'h00;
    endcase
  end
  assign int_n      = int_n_q;
  assign meas_start = start_q;
  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_start_write;
    ce && hit(REG_CMD) && rif.wdata == 8'h03;
  endsequence
  sequence s_high_run;
    ce && smp_done && hi_hit && ic_q[IC_EN] && hi_cnt_q + 8'h01 == need;
  endsequence
  a_cmd_start_run: assert property (s_start_write |=> run ##1 start_q)   // RULE1
    else $error("start command did not begin measurements");
  a_meas_only_run: assert property (start_q |-> $past(run))   // RULE1
    else $error("measurement requested while disabled");
  a_status_bit_hi: assert property (   // RULE2
    rif.addr == REG_STATUS |-> rif.rdata[ST_HI] == upper_crossing_flag_q)
    else $error("status bit 0 differs from upper flag");
  a_int_pin_low: assert property (s_high_run |=> !int_n && upper_crossing_flag_q)   // RULE3
    else $error("interrupt pin not low after high run");
  a_int_low_hold: assert property (   // RULE3
    ce && upper_crossing_flag_q && !hit(REG_STATUS) |=> !int_n)
    else $error("interrupt released without clear");
  a_status_read_int: assert property (   // RULE4
    !int_n && rif.addr == REG_STATUS |-> rif.rdata[1:0] != 2'h0)
    else $error("interrupt low but status reads clear");
  a_single_no_flag: assert property (   // RULE5
    ce && smp_done && !hi_hit && !upper_crossing_flag_q && !hit(REG_STATUS)
      |=> !upper_crossing_flag_q)
    else $error("upper flag set by result below threshold");
  a_thr_byte_write: assert property (   // RULE7
    ce && hit(REG_HI_TH_HB) |=> hi_th_q[15:8] == $past(rif.wdata))
    else $error("upper threshold high byte not written");
  a_intctl_count: assert property (   // RULE8
    ce && hit(REG_INTCTL) && rif.wdata[7:5] == 3'h1 |=> need == 8'h02)
    else $error("consecutive count not taken from control");
  a_low_flag_set: assert property (   // RULE9
    ce && smp_done && lo_hit && ic_q[IC_EN] && lo_cnt_q + 8'h01 == need
      |=> lower_crossing_flag_q ##0 !int_n)
    else $error("lower flag not set after low run");
endmodule
